// ### inc/autoneg_map.vh
// Register offsets, field positions, reset values and timing counts for negotiation control
`ifndef AUTONEG_MAP_VH
`define AUTONEG_MAP_VH
// Register offsets on the management port
`define REG_BASIC_MODE_CONTROL 5'h00
`define REG_BASIC_MODE_STATUS 5'h01
`define REG_ADVERTISED_ABILITIES 5'h04
`define REG_PARTNER_ABILITIES 5'h05
`define REG_NEGOTIATION_EXPANSION 5'h06
`define REG_LINK_STATUS_SUMMARY 5'h10
`define REG_TRANSCEIVER_CONTROL 5'h19
// Basic mode control fields
`define BMC_SPEED 13
`define BMC_NEG_EN 12
`define BMC_RESTART 9
`define BMC_DUPLEX 8
// Transceiver control fields
`define XC_AUTO_EN 15
`define XC_FORCE 14
// Fixed abilities and reset values
`define STATUS_FIXED 16'h7849
`define PD_WORD_100 16'h0081
`define PD_WORD_10 16'h0021
`define SELECTOR 5'h01
`define XCTRL_RESET 16'h8000
// Timing in milliseconds
`define BREAK_LINK_MS 1500
`define FLP_INTERVAL_MS 16
`define ACK_MS 50
`define XOVER_MS 62
`endif

// ### design/autoneg_ctrl.v
// Auto-negotiation, parallel detection and crossover control for a 10/100 transceiver
// Contract
// - When negotiation is enabled, send advertised abilities in link pulse bursts.
// - Resolve common mode: 100 full, 100 half, 10 full, 10 half.
// - Basic mode control holds negotiation enable and restart controls.
// - Negotiation off: speed and duplex come from control register bits.
// - Negotiation on: speed and duplex bits are ignored.
// - Status summary reports resolved speed once link is up.
// - Basic status shows fixed abilities and live complete, fault, link bits.
// - Advertised abilities default to all; software may suppress some.
// - Partner register captures base and next page code words; the code keeps only the first code word seen in ability detect, no next pages.
// - Parallel detect loads partner register with 0081h or 0021h.
// - Expansion register reports fault, next page, page received, partner able.
// - Both receivers report link; parallel detect picks the valid one.
// - After parallel detect, partner-able reads zero while complete is one.
// - Parallel detect fault set when both receivers report good link at once.
// - Writing one to restart bit starts a new negotiation.
// - Loss of link in negotiated mode resumes negotiation.
// - Renegotiation silences transmit for 1500 ms break link time.
// - Negotiation or parallel detection completes in about two to three seconds.
// - Automatic crossover toggles pairs under a random seed until link.
// - Automatic crossover on by default, set by strap or control bits.
// - Forced crossover bit swaps pairs regardless of other settings.
// - Straps set initial advertised ability bits 8 to 5.
`timescale 1ns/1ps
`include "autoneg_map.vh"

module autoneg_ctrl #(
  parameter CLK_KHZ = 200000,
  parameter BREAK_CYC = `BREAK_LINK_MS * CLK_KHZ,
  parameter FLP_CYC = `FLP_INTERVAL_MS * CLK_KHZ,
  parameter ACK_CYC = `ACK_MS * CLK_KHZ,
  parameter XOVER_CYC = `XOVER_MS * CLK_KHZ
) (
  // Clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // Configuration straps, pins
  input wire negotiation_enable_strap_i,
  input wire ability_strap_high_i,
  input wire ability_strap_low_i,
  input wire auto_crossover_strap_i,
  // Management register port, same clock
  input wire reg_wr_i,
  input wire [4:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  output wire [15:0] reg_rdata_o,
  // Receiver indications, from pins/other domains
  input wire link10_ok_i,
  input wire link100_ok_i,
  input wire code_word_valid_i,
  input wire [15:0] code_word_i,
  // Transmit side
  output wire flp_send_o,
  output wire [15:0] flp_word_o,
  output wire tx_quiet_o,
  output wire speed100_o,
  output wire full_duplex_o,
  output wire link_up_o,
  output wire crossover_o
);

  localparam S_IDLE = 3'd0;
  localparam S_BREAK = 3'd1;
  localparam S_ABILITY = 3'd2;
  localparam S_LINK_WAIT = 3'd3;
  localparam S_UP = 3'd4;
  localparam S_FORCED = 3'd5;

  // Two-stage synchronisers for all asynchronous inputs
  reg [20:0] sync1_q;
  reg [20:0] sync2_q;
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= 21'h0;
      sync2_q <= 21'h0;
    end else begin
      sync1_q <= {negotiation_enable_strap_i, ability_strap_high_i, ability_strap_low_i,
                  link10_ok_i, link100_ok_i, code_word_valid_i, code_word_i[14:0]};
      sync2_q <= sync1_q;
    end
  end
  // Code word bit 15 shares the sync via a separate stage pair
  reg cw15_1_q;
  reg cw15_2_q;
  reg xs_1_q;
  reg xs_2_q;
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cw15_1_q <= 1'b0;
      cw15_2_q <= 1'b0;
      xs_1_q <= 1'b0;
      xs_2_q <= 1'b0;
    end else begin
      cw15_1_q <= code_word_i[15];
      cw15_2_q <= cw15_1_q;
      xs_1_q <= auto_crossover_strap_i;
      xs_2_q <= xs_1_q;
    end
  end
  wire strap_en = sync2_q[20];
  wire strap_hi = sync2_q[19];
  wire strap_lo = sync2_q[18];
  wire l10 = sync2_q[17];
  wire l100 = sync2_q[16];
  wire cw_valid = sync2_q[15];
  wire [15:0] cw = {cw15_2_q, sync2_q[14:0]};

  // Decode of the four ability bits from the strap pins
  function [3:0] strap_abil;
    input en;
    input hi;
    input lo;
    begin
      if (!en)
        strap_abil = 4'hf;
      else
        case ({hi, lo})
          2'b00: strap_abil = 4'h3;
          2'b01: strap_abil = 4'hc;
          2'b10: strap_abil = 4'h5;
          default: strap_abil = 4'hf;
        endcase
    end
  endfunction

  // Priority resolution over the shared abilities {100fd,100hd,10fd,10hd}
  function [2:0] resolve;
    input [3:0] common;
    begin
      if (common[3])
        resolve = 3'b111;
      else if (common[2])
        resolve = 3'b110;
      else if (common[1])
        resolve = 3'b101;
      else if (common[0])
        resolve = 3'b100;
      else
        resolve = 3'b000;
    end
  endfunction

  reg [15:0] ctrl_q;
  reg [15:0] adv_q;
  reg [15:0] partner_q;
  reg [15:0] xctrl_q;
  reg strap_done_q;
  reg [2:0] state_q;
  reg [31:0] timer_q;
  reg [31:0] flp_tmr_q;
  reg [31:0] xo_tmr_q;
  reg [15:0] lfsr_q;
  reg complete_q;
  reg pd_q;
  reg pd_fault_q;
  reg partner_able_q;
  reg page_rx_q;
  reg partner_np_q;
  reg speed_q;
  reg duplex_q;
  reg link_q;
  reg xover_q;
  reg flp_q;
  reg quiet_q;
  reg [15:0] rdata_q;
  reg [1:0] strap_wait_q;

  wire wr_ctrl = reg_wr_i && (reg_addr_i == `REG_BASIC_MODE_CONTROL);
  wire wr_adv = reg_wr_i && (reg_addr_i == `REG_ADVERTISED_ABILITIES);
  wire wr_xc = reg_wr_i && (reg_addr_i == `REG_TRANSCEIVER_CONTROL);
  wire neg_en = ctrl_q[`BMC_NEG_EN];
  wire restart_req = ctrl_q[`BMC_RESTART];
  wire one_link = l10 ^ l100;
  wire [3:0] common = adv_q[8:5] & partner_q[8:5];
  wire [2:0] res = resolve(common);

  // Registers, strap load and negotiation state machine
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q <= 16'h0000;
      adv_q <= {11'h00f, `SELECTOR};
      partner_q <= 16'h0000;
      xctrl_q <= `XCTRL_RESET;
      strap_done_q <= 1'b0;
      state_q <= S_IDLE;
      timer_q <= 32'h0;
      flp_tmr_q <= 32'h0;
      complete_q <= 1'b0;
      pd_q <= 1'b0;
      pd_fault_q <= 1'b0;
      partner_able_q <= 1'b0;
      page_rx_q <= 1'b0;
      partner_np_q <= 1'b0;
      speed_q <= 1'b0;
      duplex_q <= 1'b0;
      link_q <= 1'b0;
      flp_q <= 1'b0;
      quiet_q <= 1'b0;
      strap_wait_q <= 2'b00;
    end else begin
      flp_q <= 1'b0;
      // Straps caught on the third edge after release: the second stage only holds
      // the pin level after two edges, so reading it earlier latches the reset zeros
      if (!strap_done_q) begin
        strap_wait_q <= strap_wait_q + 2'b01;
        if (strap_wait_q == 2'b10) begin
          strap_done_q <= 1'b1;
          adv_q[8:5] <= strap_abil(strap_en, strap_hi, strap_lo);
          ctrl_q[`BMC_NEG_EN] <= strap_en;
          ctrl_q[`BMC_SPEED] <= strap_hi;
          ctrl_q[`BMC_DUPLEX] <= strap_lo;
          xctrl_q[`XC_AUTO_EN] <= ~xs_2_q;
        end
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i & 16'h3300;
      end
      if (wr_adv) begin
        adv_q <= {reg_wdata_i[15:5], `SELECTOR};
      end
      if (wr_xc) begin
        xctrl_q <= {reg_wdata_i[15:14], 14'h0000};
      end
      if (timer_q != 32'h0)
        timer_q <= timer_q - 32'h1;
      case (state_q)
        S_IDLE: begin
          link_q <= 1'b0;
          complete_q <= 1'b0;
          quiet_q <= 1'b0;
          if (strap_done_q)
            state_q <= neg_en ? S_BREAK : S_FORCED;
          timer_q <= BREAK_CYC;
        end
        S_BREAK: begin
          quiet_q <= 1'b1;
          link_q <= 1'b0;
          complete_q <= 1'b0;
          if (restart_req && !wr_ctrl)
            ctrl_q[`BMC_RESTART] <= 1'b0;
          if (timer_q == 32'h0) begin
            quiet_q <= 1'b0;
            page_rx_q <= 1'b0;
            pd_q <= 1'b0;
            state_q <= S_ABILITY;
            timer_q <= ACK_CYC;
            flp_tmr_q <= 32'h0;
          end
        end
        S_ABILITY: begin
          // Bursts repeat on the interval timer
          if (flp_tmr_q == 32'h0) begin
            flp_q <= 1'b1;
            flp_tmr_q <= FLP_CYC;
          end else begin
            flp_tmr_q <= flp_tmr_q - 32'h1;
          end
          if (cw_valid) begin
            partner_q <= cw;
            page_rx_q <= 1'b1;
            partner_able_q <= 1'b1;
            partner_np_q <= cw[15];
            state_q <= S_LINK_WAIT;
          end else if (timer_q == 32'h0) begin
            if (one_link) begin
              partner_q <= l100 ? `PD_WORD_100 : `PD_WORD_10;
              partner_able_q <= 1'b0;
              pd_q <= 1'b1;
              state_q <= S_LINK_WAIT;
            end else if (l10 && l100) begin
              pd_fault_q <= 1'b1;
            end
            timer_q <= ACK_CYC;
          end
        end
        S_LINK_WAIT: begin
          if (pd_q) begin
            speed_q <= l100;
            duplex_q <= 1'b0;
          end else begin
            speed_q <= res[1];
            duplex_q <= res[0];
          end
          if (pd_q || res[2]) begin
            if (l10 | l100) begin
              complete_q <= 1'b1;
              link_q <= 1'b1;
              state_q <= S_UP;
            end
          end else begin
            state_q <= S_ABILITY;
          end
        end
        S_UP: begin
          if (!(speed_q ? l100 : l10)) begin
            timer_q <= BREAK_CYC;
            state_q <= S_BREAK;
          end
        end
        S_FORCED: begin
          complete_q <= 1'b0;
          quiet_q <= 1'b0; // Leaving a break early must not keep a forced link silent
          speed_q <= ctrl_q[`BMC_SPEED];
          duplex_q <= ctrl_q[`BMC_DUPLEX];
          link_q <= ctrl_q[`BMC_SPEED] ? l100 : l10;
        end
        default: state_q <= S_IDLE;
      endcase
      // Enable toggling and restart take priority over the current state
      if (state_q != S_IDLE) begin
        if (!neg_en && state_q != S_FORCED) begin
          state_q <= S_FORCED;
        end else if (neg_en && state_q == S_FORCED) begin
          timer_q <= BREAK_CYC;
          state_q <= S_BREAK;
        end else if (neg_en && restart_req && state_q != S_BREAK) begin
          timer_q <= BREAK_CYC;
          state_q <= S_BREAK;
        end
      end
    end
  end

  // Crossover: random toggling until link, forced bit overrides
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lfsr_q <= 16'hace1;
      xo_tmr_q <= 32'h0;
      xover_q <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      if (xctrl_q[`XC_FORCE]) begin
        xover_q <= 1'b1;
      end else if (!xctrl_q[`XC_AUTO_EN]) begin
        xover_q <= 1'b0;
      end else if (link_q || l10 || l100) begin
        xo_tmr_q <= XOVER_CYC;
      end else if (xo_tmr_q == 32'h0) begin
        xo_tmr_q <= XOVER_CYC;
        if (lfsr_q[0])
          xover_q <= ~xover_q;
      end else begin
        xo_tmr_q <= xo_tmr_q - 32'h1;
      end
    end
  end

  // Read multiplexer, registered for one-cycle read latency
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= 16'h0000;
    end else begin
      case (reg_addr_i)
        `REG_BASIC_MODE_CONTROL: rdata_q <= ctrl_q;
        `REG_BASIC_MODE_STATUS:
          rdata_q <= `STATUS_FIXED | {10'h000, complete_q, partner_q[13], 1'b0,
                     link_q, 2'b00};
        `REG_ADVERTISED_ABILITIES: rdata_q <= adv_q;
        `REG_PARTNER_ABILITIES: rdata_q <= partner_q;
        `REG_NEGOTIATION_EXPANSION:
          rdata_q <= {11'h000, pd_fault_q, partner_np_q, adv_q[15], page_rx_q,
                      partner_able_q};
        `REG_LINK_STATUS_SUMMARY:
          rdata_q <= {11'h000, complete_q, 1'b0, duplex_q, ~speed_q & link_q,
                      link_q};
        `REG_TRANSCEIVER_CONTROL: rdata_q <= xctrl_q;
        default: rdata_q <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;
  assign flp_send_o = flp_q;
  assign flp_word_o = adv_q;
  assign tx_quiet_o = quiet_q;
  assign speed100_o = speed_q;
  assign full_duplex_o = duplex_q;
  assign link_up_o = link_q;
  assign crossover_o = xover_q;

endmodule // autoneg_ctrl

// ### bench/autoneg_ctrl_properties.sv
// Port checks for the negotiation control block
`timescale 1ns/1ps
module autoneg_ctrl_properties #(
  parameter int BREAK_CYC = 50
) (
  // Clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // Register port
  input wire reg_wr_i,
  input wire [4:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  // Line side
  input wire flp_send_o,
  input wire tx_quiet_o,
  input wire speed100_o,
  input wire link_up_o,
  input wire crossover_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  int quiet_q;
  int steady_q;
  logic [1:0] lk_q;
  wire mapped = reg_addr_i inside {5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h10, 5'h19};
  wire wr0 = reg_wr_i && reg_addr_i == 5'h00;
  // Silent run length and how long link and speed have held still
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quiet_q <= 0;
      steady_q <= 0;
      lk_q <= 2'b00;
    end else begin
      quiet_q <= tx_quiet_o ? quiet_q + 1 : 0;
      lk_q <= {link_up_o, speed100_o};
      steady_q <= (lk_q == {link_up_o, speed100_o}) ? steady_q + 1 : 0;
    end
  end
  a_quiet_no_burst: assert property (tx_quiet_o |-> !flp_send_o)
    else $error("burst sent while silenced");
  a_up_not_quiet: assert property (link_up_o |-> !tx_quiet_o)
    else $error("link up while silenced");
  a_unmapped_zero: assert property (!$past(sys_rst_i) && !$past(mapped) |-> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_status_fixed: assert property (!$past(sys_rst_i) && $past(reg_addr_i) == 5'h01
    |-> (reg_rdata_o & 16'hffcb) == 16'h7849)
    else $error("fixed status bits wrong");
  a_summary_link: assert property (steady_q > 2 && $past(reg_addr_i) == 5'h10
    |-> reg_rdata_o[0] == link_up_o && (!link_up_o || reg_rdata_o[1] == !speed100_o))
    else $error("summary disagrees with link");
  a_burst_spaced: assert property (flp_send_o |=> !flp_send_o [*8])
    else $error("bursts too close");
  a_restart_quiet: assert property (wr0 && reg_wdata_i[12] && reg_wdata_i[9]
    |-> ##[1:4] tx_quiet_o)
    else $error("restart did not silence");
  a_break_time: assert property ($fell(tx_quiet_o)
    |-> quiet_q >= BREAK_CYC - 1 && quiet_q <= BREAK_CYC + 4)
    else $error("break length wrong");
  a_burst_resume: assert property ($fell(tx_quiet_o) |-> ##[0:4] flp_send_o)
    else $error("no burst after break");
  a_force_swap: assert property (reg_wr_i && reg_addr_i == 5'h19 && reg_wdata_i[14]
    |-> ##[1:3] crossover_o)
    else $error("forced crossover missing");
  c_link: cover property ($rose(link_up_o));
  c_break: cover property ($fell(tx_quiet_o));
  c_swap: cover property ($rose(crossover_o) && !link_up_o);
endmodule // autoneg_ctrl_properties
bind autoneg_ctrl autoneg_ctrl_properties #(.BREAK_CYC(BREAK_CYC)) i_props (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .flp_send_o(flp_send_o),
  .tx_quiet_o(tx_quiet_o), .speed100_o(speed100_o), .link_up_o(link_up_o),
  .crossover_o(crossover_o));

// ### bench/link_partner.sv
// Behavioural far-end transceiver on the cable
`timescale 1ns/1ps
module link_partner (
  // Clock and reset
  input wire mclk_i,
  input wire sys_rst_i,
  // Bench control: mode 0 silent, 1 negotiating, 2 fixed 100, 3 fixed 10
  input wire [1:0] mode_i,
  input wire both_i,
  input wire [15:0] word_i,
  input wire [3:0] lag_i,
  // Device transmit side
  input wire flp_send_i,
  input wire [15:0] flp_word_i,
  input wire tx_quiet_i,
  // Device receive side
  output wire link10_o,
  output wire link100_o,
  output wire cw_valid_o,
  output wire [15:0] cw_o
);
  logic [7:0] cnt_q;
  wire [3:0] common = flp_word_i[8:5] & word_i[8:5];
  wire fast = common[3] | common[2];
  wire up = mode_i == 2'd1 && cnt_q > {4'h0, lag_i} + 8'd12;
  // Word held while valid; a released line shows the inverse, not the old word
  assign cw_valid_o = mode_i == 2'd1 && cnt_q > {4'h0, lag_i};
  assign cw_o = cw_valid_o ? word_i : ~word_i;
  // Partner falls into link fail while the device is silent
  assign link100_o = !tx_quiet_i && (mode_i == 2'd2 || both_i || (up && fast));
  assign link10_o = !tx_quiet_i && (mode_i == 2'd3 || both_i || (up && !fast));
  // Answer starts a bench-chosen lag after the first burst heard
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 8'h00;
    end else if (mode_i != 2'd1 || tx_quiet_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'h00 && cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (flp_send_i && cnt_q == 8'h00) begin
      cnt_q <= 8'h01;
    end
  end
endmodule // link_partner

// ### bench/tb_autoneg_ctrl.sv
// Self-checking bench for the negotiation control block
`timescale 1ns/1ps
module tb_autoneg_ctrl;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [1:0] mode = 2'd0;
  logic both = 1'b0;
  logic [15:0] pword = 16'h0001;
  logic [3:0] lag = 4'h0;
  logic strap_en = 1'b1, strap_hi = 1'b1, strap_lo = 1'b1, xo_strap = 1'b0;
  wire [15:0] rdata, flp_word, cw;
  wire flp_send, quiet, spd, fdx, up, xo, l10, l100, cwv;
  int failures = 0;
  int cmp_count = 0;
  // Clock at 200 MHz
  always #2.5 mclk_i = ~mclk_i;
  autoneg_ctrl #(.BREAK_CYC(50), .FLP_CYC(20), .ACK_CYC(40), .XOVER_CYC(30)) i_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .negotiation_enable_strap_i(strap_en),
    .ability_strap_high_i(strap_hi), .ability_strap_low_i(strap_lo),
    .auto_crossover_strap_i(xo_strap),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(rdata), .link10_ok_i(l10), .link100_ok_i(l100), .code_word_valid_i(cwv),
    .code_word_i(cw), .flp_send_o(flp_send), .flp_word_o(flp_word), .tx_quiet_o(quiet),
    .speed100_o(spd), .full_duplex_o(fdx), .link_up_o(up), .crossover_o(xo));
  link_partner i_partner (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mode_i(mode), .both_i(both), .word_i(pword),
    .lag_i(lag), .flp_send_i(flp_send), .flp_word_i(flp_word), .tx_quiet_i(quiet),
    .link10_o(l10), .link100_o(l100), .cw_valid_o(cwv), .cw_o(cw));
  // Highest common ability wins: {speed100, full}
  function automatic logic [1:0] resolve(input logic [3:0] c);
    return c[3] ? 2'b11 : c[2] ? 2'b10 : c[1] ? 2'b01 : 2'b00;
  endfunction
  // Strap table: ability nibble {100fd,100hd,10fd,10hd}; forced straps advertise all
  function automatic logic [3:0] strap_adv(input logic en, input logic [1:0] s);
    return !en ? 4'hf : s == 2'b00 ? 4'h3 : s == 2'b01 ? 4'hc : s == 2'b10 ? 4'h5 : 4'hf;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] m,
                      input logic [15:0] e);
    @(negedge mclk_i);
    reg_addr_i = a;
    @(negedge mclk_i);
    chk(what, e, rdata & m);
  endtask
  // Bounded wait for a link level, then after link loss only a settle of 60 cycles
  task automatic wait_up(input logic v);
    int n;
    n = 0;
    while (up !== v && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    chk("link_up_o", {15'h0, v}, {15'h0, up});
    if (!v) repeat (60) @(negedge mclk_i);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #400000;
    failures++;
    $display("unexpected watchdog: expected finish seen timeout");
    test_done;
  end
  initial begin
    logic [3:0] m, p;
    logic [1:0] e;
    int i;
    i = $urandom(32'ha5bea43d);
    repeat (8) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    rchk("adv", 5'h04, 16'hffff, 16'h01e1);
    rchk("xctrl", 5'h19, 16'hffff, 16'h8000);
    rchk("status", 5'h01, 16'hffcb, 16'h7849);
    wr(5'h03, 16'hffff);
    rchk("unmapped", 5'h03, 16'hffff, 16'h0000);
    wr(5'h05, 16'h1234);
    rchk("partner ro", 5'h05, 16'hffff, 16'h0000);
    $display("test reset done");
    // Single-ability corners first, then random ability sets
    for (i = 0; i < 7; i++) begin
      m = (i < 4) ? 4'h1 << i : 4'($urandom_range(15, 1));
      p = (i < 4) ? 4'hf : 4'($urandom) | (m & (~m + 4'h1));
      e = resolve(m & p);
      pword = {2'b00, 1'($urandom), 4'h0, p, 5'h01};
      lag = 4'($urandom);
      mode = 2'd1;
      wr(5'h04, {7'h00, m, 5'h01});
      wr(5'h00, {2'b00, 1'($urandom), 1'b1, 2'b00, 1'b1, 1'($urandom), 8'h00});
      wait_up(1'b1);
      chk("mode", {14'h0, e}, {14'h0, spd, fdx});
      chk("word", {7'h00, m, 5'h01}, flp_word);
      rchk("partner", 5'h05, 16'hffff, pword);
      rchk("restart", 5'h00, 16'h0200, 16'h0000);
      rchk("live status", 5'h01, 16'h0034, {10'h0, 1'b1, pword[13], 4'h4});
      rchk("summary", 5'h10, 16'h0017, {11'h0, 1'b1, 1'b0, e[0], ~e[1], 1'b1});
      rchk("expansion", 5'h06, 16'h000f, 16'h0003);
      mode = 2'd0;
      wait_up(1'b0);
    end
    $display("test negotiation done");
    for (i = 0; i < 4; i++) begin
      wr(5'h00, {2'b00, 1'(i >> 1), 4'h0, 1'(i), 8'h00});
      repeat (3) @(negedge mclk_i);
      chk("forced", {14'h0, 2'(i)}, {14'h0, spd, fdx});
    end
    for (i = 0; i < 2; i++) begin
      wr(5'h00, 16'h0000);
      wr(5'h00, 16'h1200);
      // Partner appears only after forced mode is left, so no stale forced link is seen
      mode = i ? 2'd3 : 2'd2;
      wait_up(1'b1);
      chk("pd mode", {14'h0, i ? 2'b00 : 2'b10}, {14'h0, spd, fdx});
      rchk("pd partner", 5'h05, 16'hffff, i ? 16'h0021 : 16'h0081);
      rchk("pd able", 5'h06, 16'h0001, 16'h0000);
      rchk("pd complete", 5'h01, 16'h0020, 16'h0020);
      mode = 2'd0;
      wait_up(1'b0);
    end
    $display("test parallel done");
    wr(5'h00, 16'h0000);
    wr(5'h19, 16'h4000);
    repeat (3) @(negedge mclk_i);
    chk("swap", 16'h0001, {15'h0, xo});
    wr(5'h19, 16'h0000);
    repeat (3) @(negedge mclk_i);
    chk("no swap", 16'h0000, {15'h0, xo});
    wr(5'h19, 16'h8000);
    wr(5'h00, 16'h1200);
    p = {3'h0, xo};
    for (i = 0; i < 800 && xo === p[0]; i++) @(negedge mclk_i);
    chk("auto swap", {15'h0, ~p[0]}, {15'h0, xo});
    $display("test crossover done");
    mode = 2'd2;
    both = 1'b1;
    wr(5'h00, 16'h1200);
    for (i = 0; i < 300 && rdata[4] !== 1'b1; i++) rchk("poll", 5'h06, 16'h0000, 16'h0000);
    rchk("pd fault", 5'h06, 16'h0010, 16'h0010);
    chk("fault link", 16'h0000, {15'h0, up});
    $display("test fault done");
    // Reset again in mid-run: forced straps, then advertising straps, crossover strap set
    for (i = 0; i < 2; i++) begin
      sys_rst_i = 1'b1;
      e = 2'($urandom);
      {strap_hi, strap_lo} = e;
      strap_en = 1'(i);
      xo_strap = 1'b1;
      repeat (8) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      rchk("strap adv", 5'h04, 16'hffff, {7'h00, strap_adv(strap_en, e), 5'h01});
      rchk("strap ctrl", 5'h00, 16'h3100, {2'b00, e[1], strap_en, 3'b000, e[0], 8'h00});
      rchk("strap xctrl", 5'h19, 16'hffff, 16'h0000);
      if (!strap_en) chk("strap mode", {14'h0, e}, {14'h0, spd, fdx});
    end
    $display("test strap done");
    test_done;
  end
endmodule // tb_autoneg_ctrl
